// >>> sbcwd_if.sv
// Internal carrier between the supervisor, its watchdog timer and its reset pulse generator.
`timescale 1ns/1ps
`default_nettype none
interface sbcwd_if;
   logic tmr_run;
   logic tmr_restart;
   logic [15:0] tmr_len;
   logic tmr_second_half;
   logic tmr_ovf;
   logic rg_start;
   logic rg_cold;
   logic [1:0] rg_width_sel;
   logic rg_busy;
   logic rg_drive;
   modport tmr (input tmr_run, tmr_restart, tmr_len, output tmr_second_half, tmr_ovf);
   modport rg (input rg_start, rg_cold, rg_width_sel, output rg_busy, rg_drive);
endinterface
`default_nettype wire

// >>> sbcwd_mcu.sv
// Microcontroller side of the open-drain reset pin, with the pin pull-up.
`timescale 1ns/1ps
`default_nettype none
module sbcwd_mcu #(
   parameter int HOLD_CYC = 8
) (
   input wire logic clk,
   input wire logic pull_req,
   input wire logic dev_oe,
   input wire logic dev_out,
   output logic pin
);
   int cnt_reg = 0;
   // Once asked, the line is held low for HOLD_CYC clock cycles, 8 by default.
   always @(posedge clk) begin
      if (pull_req) begin
         cnt_reg <= HOLD_CYC;
      end else if (cnt_reg > 0) begin
         cnt_reg <= cnt_reg - 1;
      end
   end
   // The pull-up returns the line high when no party pulls it low.
   assign pin = ((dev_oe && !dev_out) || cnt_reg > 0) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// >>> sbcwd_pkg.sv
// Constants, types and decode helpers of the watchdog and reset block.
package sbcwd_pkg;
   localparam int CLK_PERIOD_NS = 50;
   localparam int TICK_NS = 100000;
   localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TICKS_PER_MS = 1000000 / TICK_NS;
   localparam int RST_BLANK_CYC = 3;
   localparam int EXT_RST_MIN_NS = 1000;
   localparam int EXT_RST_CYC = (EXT_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_W0_US = 20000;
   localparam int RST_W1_US = 10000;
   localparam int RST_W2_US = 3600;
   localparam int RST_W3_US = 1000;

   localparam logic [6:0] WDCTL_ADDR = 7'h00;
   localparam logic [6:0] WDSTAT_ADDR = 7'h05;
   localparam logic [6:0] STARTUP_ADDR = 7'h73;
   localparam logic [6:0] CFG_ADDR = 7'h74;

   localparam int MODE_LSB = 5;
   localparam int PERIOD_LSB = 0;
   localparam int UVSEL_LSB = 4;
   localparam int FN_BIT = 3;
   localparam int SD_BIT = 2;
   localparam int RLC_LSB = 4;
   localparam logic [7:0] CFG_WMASK = 8'h3C;
   localparam logic [7:0] CFG_PRESET = 8'h08;
   localparam logic [1:0] RLC_RESET = 2'h0;
   localparam logic [1:0] RLC_SHORTEST = 2'h3;
   localparam logic [1:0] UVSEL_RESET = 2'h0;
   localparam logic [1:0] SYNC_IDLE_HIGH = 2'h3;

   localparam logic [2:0] WMC_AUTO = 3'h1;
   localparam logic [2:0] WMC_TIMEOUT = 3'h2;
   localparam logic [2:0] WMC_WINDOW = 3'h4;
   localparam logic [3:0] NWP_DEFAULT = 4'h4;

   localparam logic [1:0] WDS_OFF = 2'h0;
   localparam logic [1:0] WDS_FIRST = 2'h1;
   localparam logic [1:0] WDS_SECOND = 2'h2;

   localparam logic [1:0] OP_OTHER = 2'h0;
   localparam logic [1:0] OP_NORMAL = 2'h1;
   localparam logic [1:0] OP_STANDBY = 2'h2;

   localparam logic [4:0] RSS_POWER_ON = 5'h00;
   localparam logic [4:0] RSS_EARLY = 5'h0E;
   localparam logic [4:0] RSS_OVERFLOW = 5'h0F;
   localparam logic [4:0] RSS_ILLEGAL = 5'h10;
   localparam logic [4:0] RSS_EXTERNAL = 5'h11;
   localparam logic [4:0] RSS_OVERTEMP = 5'h12;
   localparam logic [4:0] RSS_UNDERVOLT = 5'h13;

   typedef enum logic [1:0] {WD_OFF = 2'h0, WD_TIMEOUT = 2'h1, WD_WINDOW = 2'h3} sbcwd_beh_t;
   typedef enum logic [1:0] {RG_IDLE = 2'h0, RG_PULSE = 2'h1, RG_BLANK = 2'h3} sbcwd_rg_state_t;

   // Returns the period in timer ticks, or zero for a code that is not accepted.
   function automatic logic [15:0] period_ticks(input logic [3:0] code);
      int ms;
      ms = 0;
      case (code)
         4'h8: ms = 8;
         4'h1: ms = 16;
         4'h2: ms = 32;
         4'hB: ms = 64;
         4'h4: ms = 128;
         4'hD: ms = 256;
         4'hE: ms = 1024;
         4'h7: ms = 4096;
         default: ms = 0;
      endcase
      return 16'(ms * TICKS_PER_MS);
   endfunction

   function automatic logic mode_ok(input logic [2:0] code);
      return (code == WMC_AUTO) || (code == WMC_TIMEOUT) || (code == WMC_WINDOW);
   endfunction

   // Least reset pulse width of a width code, in ticks rounded up.
   function automatic logic [7:0] rst_ticks(input logic [1:0] sel);
      int us;
      us = RST_W3_US;
      case (sel)
         2'h0: us = RST_W0_US;
         2'h1: us = RST_W1_US;
         2'h2: us = RST_W2_US;
         default: us = RST_W3_US;
      endcase
      return 8'((us * 1000 + TICK_NS - 1) / TICK_NS);
   endfunction
endpackage

// >>> sbcwd_rstgen.sv
// Reset pulse generator for the open-drain reset pin.
`timescale 1ns/1ps
`default_nettype none
module sbcwd_rstgen #(
   parameter int TICK_CYC = sbcwd_pkg::TICK_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   sbcwd_if.rg bus
);
   typedef struct packed {
      sbcwd_pkg::sbcwd_rg_state_t state;
      logic [15:0] presc;
      logic [7:0] ticks;
      logic [7:0] tgt;
   } sbcwd_rg_st_t;

   sbcwd_rg_st_t st_reg;
   sbcwd_rg_st_t st_next;

   // The blank phase covers the pin synchroniser so the own pulse is not seen as external.
   always_comb begin
      st_next = st_reg;
      unique case (st_reg.state)
         sbcwd_pkg::RG_IDLE: begin
            if (bus.rg_start) begin
               st_next.state = sbcwd_pkg::RG_PULSE;
               st_next.presc = '0;
               st_next.ticks = '0;
               if (bus.rg_cold) begin
                  st_next.tgt = sbcwd_pkg::rst_ticks(bus.rg_width_sel);
               end else begin
                  st_next.tgt = sbcwd_pkg::rst_ticks(sbcwd_pkg::RLC_SHORTEST);
               end
            end
         end
         sbcwd_pkg::RG_PULSE: begin
            st_next.presc = st_reg.presc + 16'h0001;
            if (st_reg.presc == 16'(TICK_CYC - 1)) begin
               st_next.presc = '0;
               st_next.ticks = st_reg.ticks + 8'h01;
               if (st_reg.ticks + 8'h01 >= st_reg.tgt) begin
                  st_next.state = sbcwd_pkg::RG_BLANK;
               end
            end
         end
         sbcwd_pkg::RG_BLANK: begin
            st_next.presc = st_reg.presc + 16'h0001;
            if (st_reg.presc == 16'(sbcwd_pkg::RST_BLANK_CYC - 1)) begin
               st_next.presc = '0;
               st_next.state = sbcwd_pkg::RG_IDLE;
            end
         end
         default: begin
            st_next.state = sbcwd_pkg::RG_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '{state: sbcwd_pkg::RG_IDLE, default: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign bus.rg_drive = (st_reg.state == sbcwd_pkg::RG_PULSE);
   assign bus.rg_busy = (st_reg.state != sbcwd_pkg::RG_IDLE);

   sequence s_launch;
      bus.rg_start && st_reg.state == sbcwd_pkg::RG_IDLE;
   endsequence

   a_pulse_low: assert property (@(posedge clk) disable iff (!rst_n)
      s_launch |=> bus.rg_drive [*8])
      else $error("Reset pin not driven after a system reset.");
   a_warm_width: assert property (@(posedge clk) disable iff (!rst_n)
      s_launch and !bus.rg_cold |=> st_reg.tgt == sbcwd_pkg::rst_ticks(sbcwd_pkg::RLC_SHORTEST))
      else $error("Warm start did not pick the shortest pulse.");
   a_cold_width: assert property (@(posedge clk) disable iff (!rst_n)
      s_launch and bus.rg_cold |=> st_reg.tgt == sbcwd_pkg::rst_ticks($past(bus.rg_width_sel)))
      else $error("Cold start did not use the programmed width.");
endmodule
`default_nettype wire

// >>> sbcwd_timer.sv
// Watchdog period timer with half-period flag and overflow pulse.
`timescale 1ns/1ps
`default_nettype none
module sbcwd_timer #(
   parameter int TICK_CYC = sbcwd_pkg::TICK_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   sbcwd_if.tmr bus
);
   typedef struct packed {
      logic [15:0] presc;
      logic [15:0] cnt;
      logic ovf;
   } sbcwd_tmr_st_t;

   sbcwd_tmr_st_t st_reg;
   sbcwd_tmr_st_t st_next;

   // The count restarts by itself after an overflow, so the timer runs continuously.
   always_comb begin
      st_next = st_reg;
      st_next.ovf = 1'b0;
      if (bus.tmr_restart || !bus.tmr_run) begin
         st_next.presc = '0;
         st_next.cnt = '0;
      end else if (st_reg.presc == 16'(TICK_CYC - 1)) begin
         st_next.presc = '0;
         if (st_reg.cnt + 16'h0001 >= bus.tmr_len) begin
            st_next.cnt = '0;
            st_next.ovf = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + 16'h0001;
         end
      end else begin
         st_next.presc = st_reg.presc + 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign bus.tmr_ovf = st_reg.ovf;
   assign bus.tmr_second_half = bus.tmr_run && (st_reg.cnt >= (bus.tmr_len >> 1));

   a_ovf_at_end: assert property (@(posedge clk) disable iff (!rst_n)
      bus.tmr_ovf |-> st_reg.cnt == 16'h0000 && $past(st_reg.cnt) + 16'h0001 >= $past(bus.tmr_len))
      else $error("Overflow before the end of the period.");
   a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      !bus.tmr_run |=> !bus.tmr_ovf && st_reg.cnt == 16'h0000)
      else $error("Stopped timer overflowed.");
endmodule
`default_nettype wire

// >>> sbcwd_top.sv
// Watchdog supervisor and system reset control of the basis chip.
`timescale 1ns/1ps
`default_nettype none
module sbcwd_top #(
   parameter int TICK_CYC = sbcwd_pkg::TICK_CYC,
   parameter int EXT_RST_CYC = sbcwd_pkg::EXT_RST_CYC
) (
   input wire logic REF_CLK,
   input wire logic RESETN,
   input wire logic REG_WR,
   input wire logic [6:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   output logic SPI_FAIL,
   input wire logic [1:0] SBC_MODE,
   input wire logic RXD_IN,
   output logic RXD_FORCE_LOW,
   input wire logic WAKE_EVENT,
   input wire logic V1_UNDERVOLT,
   input wire logic POWER_ON,
   input wire logic OVERTEMP_EXIT,
   input wire logic RESET_OUT_PIN_IN,
   output logic RESET_OUT_PIN_OUT,
   output logic RESET_OUT_PIN_OE,
   output logic RESET_MODE_REQ,
   output logic [4:0] RESET_SOURCE,
   output logic WDF_PENDING,
   input wire logic WDF_CLEAR,
   output logic CYCLIC_WAKE,
   output logic [1:0] UV_THRESHOLD_SEL
);
   typedef struct packed {
      logic [1:0] rxd_s;
      logic [1:0] reset_out_pin_s;
      logic [1:0] uv_s;
      logic uv_prev;
      logic [2:0] watchdog_mode_select;
      logic [3:0] watchdog_period_select;
      logic [1:0] reset_width_select;
      logic [7:0] cfg;
      logic [1:0] uvsel;
      logic [4:0] reset_source;
      logic watchdog_failure_event;
      logic rxd_force;
      sbcwd_pkg::sbcwd_beh_t beh;
      logic restart;
      logic [7:0] rdata;
      logic spi_fail;
      logic rst_req;
      logic cold;
      logic wake;
      logic [7:0] ext_cnt;
   } sbcwd_top_st_t;

   sbcwd_top_st_t st_reg;
   sbcwd_top_st_t st_next;
   sbcwd_pkg::sbcwd_beh_t beh;
   sbcwd_if bus();

   sbcwd_timer #(.TICK_CYC(TICK_CYC)) u_timer (
      .clk(REF_CLK),
      .rst_n(RESETN),
      .bus(bus.tmr)
   );

   sbcwd_rstgen #(.TICK_CYC(TICK_CYC)) u_rstgen (
      .clk(REF_CLK),
      .rst_n(RESETN),
      .bus(bus.rg)
   );

   // Watchdog behaviour from overrides, selected mode and chip operating mode.
   always_comb begin
      logic fn;
      logic sd;
      logic rxd_low;
      fn = st_reg.cfg[sbcwd_pkg::FN_BIT];
      sd = st_reg.cfg[sbcwd_pkg::SD_BIT];
      rxd_low = !st_reg.rxd_s[1] || st_reg.rxd_force;
      beh = sbcwd_pkg::WD_OFF;
      if (!fn) begin
         if (SBC_MODE == sbcwd_pkg::OP_NORMAL) begin
            if (st_reg.watchdog_mode_select == sbcwd_pkg::WMC_WINDOW) begin
               beh = sbcwd_pkg::WD_WINDOW;
            end else if (st_reg.watchdog_mode_select == sbcwd_pkg::WMC_TIMEOUT || !sd) begin
               beh = sbcwd_pkg::WD_TIMEOUT;
            end
         end else if (SBC_MODE == sbcwd_pkg::OP_STANDBY) begin
            if (st_reg.watchdog_mode_select != sbcwd_pkg::WMC_AUTO) begin
               beh = sbcwd_pkg::WD_TIMEOUT;
            end else if (!sd && rxd_low) begin
               beh = sbcwd_pkg::WD_TIMEOUT;
            end
         end
      end
   end

   always_comb begin
      logic [2:0] new_mode;
      logic [3:0] new_per;
      logic wd_wr;
      logic valid;
      logic trig;
      logic fire;
      logic [4:0] cause;
      logic [1:0] watchdog_state;
      new_mode = REG_WDATA[sbcwd_pkg::MODE_LSB +: 3];
      new_per = REG_WDATA[sbcwd_pkg::PERIOD_LSB +: 4];
      wd_wr = REG_WR && (REG_ADDR == sbcwd_pkg::WDCTL_ADDR);
      valid = sbcwd_pkg::mode_ok(new_mode) && (sbcwd_pkg::period_ticks(new_per) != 16'h0000);
      trig = 1'b0;
      fire = 1'b0;
      cause = st_reg.reset_source;
      watchdog_state = sbcwd_pkg::WDS_OFF;
      st_next = st_reg;
      st_next.rxd_s = {st_reg.rxd_s[0], RXD_IN};
      st_next.reset_out_pin_s = {st_reg.reset_out_pin_s[0], RESET_OUT_PIN_IN};
      st_next.uv_s = {st_reg.uv_s[0], V1_UNDERVOLT};
      st_next.uv_prev = st_reg.uv_s[1];
      st_next.spi_fail = 1'b0;
      st_next.rst_req = 1'b0;
      st_next.wake = 1'b0;
      st_next.beh = beh;

      if (wd_wr && !valid) begin
         st_next.spi_fail = 1'b1;
      end else if (wd_wr && SBC_MODE == sbcwd_pkg::OP_NORMAL && new_mode != st_reg.watchdog_mode_select) begin
         fire = 1'b1;
         cause = sbcwd_pkg::RSS_ILLEGAL;
      end else if (wd_wr) begin
         st_next.watchdog_mode_select = new_mode;
         st_next.watchdog_period_select = new_per;
         trig = 1'b1;
         if (st_reg.beh == sbcwd_pkg::WD_WINDOW && !bus.tmr_second_half) begin
            fire = 1'b1;
            cause = sbcwd_pkg::RSS_EARLY;
         end
      end
      if (REG_WR && REG_ADDR == sbcwd_pkg::STARTUP_ADDR) begin
         st_next.reset_width_select = REG_WDATA[sbcwd_pkg::RLC_LSB +: 2];
      end
      if (REG_WR && REG_ADDR == sbcwd_pkg::CFG_ADDR) begin
         st_next.cfg = REG_WDATA & sbcwd_pkg::CFG_WMASK;
      end

      // A failure set by an overflow wins over a clear in the same cycle.
      if (WDF_CLEAR) begin
         st_next.watchdog_failure_event = 1'b0;
      end
      if (bus.tmr_ovf && st_reg.beh == sbcwd_pkg::WD_WINDOW) begin
         fire = 1'b1;
         cause = sbcwd_pkg::RSS_OVERFLOW;
      end
      if (bus.tmr_ovf && st_reg.beh == sbcwd_pkg::WD_TIMEOUT) begin
         if (st_reg.watchdog_failure_event) begin
            fire = 1'b1;
            cause = sbcwd_pkg::RSS_OVERFLOW;
         end else begin
            st_next.watchdog_failure_event = 1'b1;
         end
         if (SBC_MODE == sbcwd_pkg::OP_STANDBY) begin
            st_next.wake = 1'b1;
         end
      end

      if (SBC_MODE != sbcwd_pkg::OP_STANDBY) begin
         st_next.rxd_force = 1'b0;
      end
      if (WAKE_EVENT && SBC_MODE == sbcwd_pkg::OP_STANDBY) begin
         st_next.rxd_force = 1'b1;
      end

      // Own drive and its echo through the synchroniser are masked by the busy flag.
      if (!st_reg.reset_out_pin_s[1] && !bus.rg_busy && !st_reg.rst_req) begin
         if (st_reg.ext_cnt != 8'hFF) begin
            st_next.ext_cnt = st_reg.ext_cnt + 8'h01;
         end
      end else begin
         st_next.ext_cnt = 8'h00;
      end
      if (st_reg.ext_cnt == 8'(EXT_RST_CYC - 1)) begin
         fire = 1'b1;
         cause = sbcwd_pkg::RSS_EXTERNAL;
      end
      if (OVERTEMP_EXIT) begin
         fire = 1'b1;
         cause = sbcwd_pkg::RSS_OVERTEMP;
      end
      if (POWER_ON) begin
         fire = 1'b1;
         cause = sbcwd_pkg::RSS_POWER_ON;
         st_next.uvsel = st_reg.cfg[sbcwd_pkg::UVSEL_LSB +: 2];
      end
      if (st_reg.uv_s[1] && !st_reg.uv_prev) begin
         fire = 1'b1;
         cause = sbcwd_pkg::RSS_UNDERVOLT;
      end

      if (fire && !bus.rg_busy && !st_reg.rst_req) begin
         st_next.reset_source = cause;
         st_next.rst_req = 1'b1;
         st_next.cold = st_reg.uv_s[1] || cause == sbcwd_pkg::RSS_POWER_ON
            || cause == sbcwd_pkg::RSS_OVERTEMP || cause == sbcwd_pkg::RSS_UNDERVOLT;
         st_next.watchdog_period_select = sbcwd_pkg::NWP_DEFAULT;
         if (st_reg.cfg[sbcwd_pkg::SD_BIT]) begin
            st_next.watchdog_mode_select = sbcwd_pkg::WMC_AUTO;
         end else begin
            st_next.watchdog_mode_select = sbcwd_pkg::WMC_TIMEOUT;
         end
      end
      st_next.restart = trig || st_next.rst_req || (beh != st_reg.beh);

      if (st_reg.beh == sbcwd_pkg::WD_OFF) begin
         watchdog_state = sbcwd_pkg::WDS_OFF;
      end else if (bus.tmr_second_half) begin
         watchdog_state = sbcwd_pkg::WDS_SECOND;
      end else begin
         watchdog_state = sbcwd_pkg::WDS_FIRST;
      end
      case (REG_ADDR)
         sbcwd_pkg::WDCTL_ADDR: st_next.rdata = {st_reg.watchdog_mode_select, 1'b0, st_reg.watchdog_period_select};
         sbcwd_pkg::WDSTAT_ADDR: st_next.rdata = {4'h0, st_reg.cfg[3:2], watchdog_state};
         sbcwd_pkg::STARTUP_ADDR: st_next.rdata = {2'h0, st_reg.reset_width_select, 4'h0};
         sbcwd_pkg::CFG_ADDR: st_next.rdata = st_reg.cfg;
         default: st_next.rdata = 8'h00;
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         st_reg <= '{rxd_s: sbcwd_pkg::SYNC_IDLE_HIGH, reset_out_pin_s: sbcwd_pkg::SYNC_IDLE_HIGH,
            watchdog_mode_select: sbcwd_pkg::WMC_TIMEOUT, watchdog_period_select: sbcwd_pkg::NWP_DEFAULT,
            reset_width_select: sbcwd_pkg::RLC_RESET, cfg: sbcwd_pkg::CFG_PRESET,
            uvsel: sbcwd_pkg::UVSEL_RESET, reset_source: sbcwd_pkg::RSS_POWER_ON,
            beh: sbcwd_pkg::WD_OFF, default: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign bus.tmr_run = (st_reg.beh != sbcwd_pkg::WD_OFF);
   assign bus.tmr_restart = st_reg.restart;
   assign bus.tmr_len = sbcwd_pkg::period_ticks(st_reg.watchdog_period_select);
   assign bus.rg_start = st_reg.rst_req;
   assign bus.rg_cold = st_reg.cold;
   assign bus.rg_width_sel = st_reg.reset_width_select;

   assign REG_RDATA = st_reg.rdata;
   assign SPI_FAIL = st_reg.spi_fail;
   assign RXD_FORCE_LOW = st_reg.rxd_force;
   assign RESET_OUT_PIN_OUT = 1'b0;
   assign RESET_OUT_PIN_OE = bus.rg_drive;
   assign RESET_MODE_REQ = st_reg.rst_req;
   assign RESET_SOURCE = st_reg.reset_source;
   assign WDF_PENDING = st_reg.watchdog_failure_event;
   assign CYCLIC_WAKE = st_reg.wake;
   assign UV_THRESHOLD_SEL = st_reg.uvsel;

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RESETN);

   a_forced_off: assert property (
      st_reg.cfg[sbcwd_pkg::FN_BIT] |=> st_reg.beh == sbcwd_pkg::WD_OFF)
      else $error("Watchdog ran with forced-normal enabled.");
   a_bad_code: assert property (
      REG_WR && REG_ADDR == sbcwd_pkg::WDCTL_ADDR && !sbcwd_pkg::mode_ok(REG_WDATA[7:5])
      |=> SPI_FAIL && $stable(st_reg.watchdog_period_select))
      else $error("Invalid mode code was not refused.");
   a_illegal_change: assert property (
      REG_WR && REG_ADDR == sbcwd_pkg::WDCTL_ADDR && SBC_MODE == sbcwd_pkg::OP_NORMAL
      && sbcwd_pkg::mode_ok(REG_WDATA[7:5]) && REG_WDATA[7:5] != st_reg.watchdog_mode_select
      && sbcwd_pkg::period_ticks(REG_WDATA[3:0]) != 16'h0000 && !bus.rg_busy && !st_reg.rst_req
      |=> RESET_MODE_REQ)
      else $error("Mode change in normal mode gave no reset.");
   a_sd_default: assert property (RESET_MODE_REQ && $past(st_reg.cfg[sbcwd_pkg::SD_BIT])
      |-> st_reg.watchdog_mode_select == sbcwd_pkg::WMC_AUTO)
      else $error("Software-dev reset did not load autonomous mode.");
   a_window_only: assert property (st_reg.beh == sbcwd_pkg::WD_WINDOW
      |-> $past(st_reg.watchdog_mode_select) == sbcwd_pkg::WMC_WINDOW && $past(SBC_MODE) == sbcwd_pkg::OP_NORMAL)
      else $error("Window behaviour outside normal mode.");
   a_status_bits: assert property (REG_ADDR == sbcwd_pkg::WDSTAT_ADDR
      |=> REG_RDATA[3:2] == $past(st_reg.cfg[3:2]) && REG_RDATA[7:4] == 4'h0)
      else $error("Status register overrides wrong.");
   a_fail_set: assert property (
      bus.tmr_ovf && st_reg.beh == sbcwd_pkg::WD_TIMEOUT && !st_reg.watchdog_failure_event |=> WDF_PENDING)
      else $error("Timeout overflow did not set the failure.");
   a_cyclic_wake: assert property (bus.tmr_ovf && st_reg.beh == sbcwd_pkg::WD_TIMEOUT
      && SBC_MODE == sbcwd_pkg::OP_STANDBY |=> CYCLIC_WAKE)
      else $error("Standby overflow gave no wake-up.");
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking testbench of the watchdog and reset block.
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int TK = 4;
   logic clk = 1'b0, rst_n, wr, rxd, wake, uv, por, otx, pin, oe, out_w, rmr, watchdog_failure_event, wdf_clr;
   logic pull, spi_fail, cyc_wake, rxd_force;
   logic [6:0] addr;
   logic [7:0] wdata, rdata;
   logic [1:0] sbc_mode, uvsel;
   logic [4:0] rsrc;
   int error_cnt = 0, checks = 0, fail_cnt = 0, rmr_cnt = 0, wake_cnt = 0;
   always #25 clk = ~clk;
   sbcwd_top #(.TICK_CYC(TK), .EXT_RST_CYC(3)) dut (.REF_CLK(clk), .RESETN(rst_n),
      .REG_WR(wr), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
      .SPI_FAIL(spi_fail), .SBC_MODE(sbc_mode), .RXD_IN(rxd), .RXD_FORCE_LOW(rxd_force),
      .WAKE_EVENT(wake), .V1_UNDERVOLT(uv), .POWER_ON(por), .OVERTEMP_EXIT(otx),
      .RESET_OUT_PIN_IN(pin), .RESET_OUT_PIN_OUT(out_w), .RESET_OUT_PIN_OE(oe), .RESET_MODE_REQ(rmr),
      .RESET_SOURCE(rsrc), .WDF_PENDING(watchdog_failure_event), .WDF_CLEAR(wdf_clr),
      .CYCLIC_WAKE(cyc_wake), .UV_THRESHOLD_SEL(uvsel));
   sbcwd_mcu mcu (.clk(clk), .pull_req(pull), .dev_oe(oe), .dev_out(out_w), .pin(pin));
   always @(posedge clk) begin
      if (spi_fail === 1'b1) fail_cnt <= fail_cnt + 1;
      if (rmr === 1'b1) rmr_cnt <= rmr_cnt + 1;
      if (cyc_wake === 1'b1) wake_cnt <= wake_cnt + 1;
   end
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk);
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic rd_reg(input logic [6:0] a, input logic [7:0] exp);
      @(negedge clk);
      addr = a;
      @(negedge clk);
      cmp(16'(rdata), 16'(exp));
   endtask
   // Waits for a system reset, checks its cause, then the length of the pin pulse.
   task automatic wait_rst(input logic [4:0] src, input int width);
      int n;
      int start;
      n = 0;
      start = rmr_cnt;
      while (rmr_cnt == start && n < 2000) begin
         @(negedge clk);
         n++;
      end
      cmp(16'(rmr_cnt - start), 16'h0001);
      cmp(16'(rsrc), 16'(src));
      n = 0;
      while (oe !== 1'b1 && n < 10) begin
         @(negedge clk);
         n++;
      end
      n = 0;
      while (oe === 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      cmp(16'(n), 16'(width));
      repeat (6) @(negedge clk);
   endtask
   task automatic stop_test;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      #400000;
      error_cnt++;
      stop_test;
   end
   initial begin
      {rst_n, wr, wake, uv, por, otx, wdf_clr, pull} = 8'h00;
      rxd = 1'b1;
      addr = 7'h00;
      wdata = 8'h00;
      sbc_mode = sbcwd_pkg::OP_NORMAL;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      rd_reg(sbcwd_pkg::CFG_ADDR, 8'h08);
      rd_reg(sbcwd_pkg::WDCTL_ADDR, 8'h44);
      rd_reg(sbcwd_pkg::WDSTAT_ADDR, 8'h08);
      wr_reg(sbcwd_pkg::CFG_ADDR, 8'h30);
      rd_reg(sbcwd_pkg::CFG_ADDR, 8'h30);
      rd_reg(sbcwd_pkg::WDSTAT_ADDR, 8'h01);
      wr_reg(sbcwd_pkg::WDCTL_ADDR, 8'h68);
      repeat (3) @(negedge clk);
      cmp(16'(fail_cnt), 16'h0001);
      rd_reg(sbcwd_pkg::WDCTL_ADDR, 8'h44);
      wr_reg(sbcwd_pkg::WDCTL_ADDR, 8'h48);
      rd_reg(sbcwd_pkg::WDCTL_ADDR, 8'h48);
      repeat (80 * TK + 8) @(negedge clk);
      cmp(16'(watchdog_failure_event), 16'h0001);
      wait_rst(sbcwd_pkg::RSS_OVERFLOW, 10 * TK);
      rd_reg(sbcwd_pkg::WDCTL_ADDR, 8'h44);
      wr_reg(sbcwd_pkg::WDCTL_ADDR, 8'h84);
      wait_rst(sbcwd_pkg::RSS_ILLEGAL, 10 * TK);
      @(negedge clk);
      pull = 1'b1;
      @(negedge clk);
      pull = 1'b0;
      wait_rst(sbcwd_pkg::RSS_EXTERNAL, 10 * TK);
      wr_reg(sbcwd_pkg::CFG_ADDR, 8'h34);
      wr_reg(sbcwd_pkg::WDCTL_ADDR, 8'h84);
      wait_rst(sbcwd_pkg::RSS_ILLEGAL, 10 * TK);
      rd_reg(sbcwd_pkg::WDCTL_ADDR, 8'h24);
      rd_reg(sbcwd_pkg::WDSTAT_ADDR, 8'h04);
      wdf_clr = 1'b1;
      @(negedge clk);
      wdf_clr = 1'b0;
      cmp(16'(watchdog_failure_event), 16'h0000);
      sbc_mode = sbcwd_pkg::OP_STANDBY;
      wake = 1'b1;
      @(negedge clk);
      wake = 1'b0;
      cmp(16'(rxd_force), 16'h0001);
      wr_reg(sbcwd_pkg::WDCTL_ADDR, 8'h88);
      rd_reg(sbcwd_pkg::WDCTL_ADDR, 8'h88);
      rd_reg(sbcwd_pkg::WDSTAT_ADDR, 8'h05);
      repeat (80 * TK + 8) @(negedge clk);
      cmp(16'(wake_cnt), 16'h0001);
      cmp(16'(watchdog_failure_event), 16'h0001);
      sbc_mode = sbcwd_pkg::OP_NORMAL;
      repeat (60 * TK) @(negedge clk);
      cmp(16'(rxd_force), 16'h0000);
      wr_reg(sbcwd_pkg::WDCTL_ADDR, 8'h88);
      rd_reg(sbcwd_pkg::WDSTAT_ADDR, 8'h05);
      cmp(16'(rmr_cnt), 16'h0004);
      wr_reg(sbcwd_pkg::WDCTL_ADDR, 8'h88);
      wait_rst(sbcwd_pkg::RSS_EARLY, 10 * TK);
      @(negedge clk);
      por = 1'b1;
      @(negedge clk);
      por = 1'b0;
      wait_rst(sbcwd_pkg::RSS_POWER_ON, 200 * TK);
      cmp(16'(uvsel), 16'h0003);
      stop_test;
   end
endmodule
`default_nettype wire
